//--- core/ris_defines.vh
// Purpose: Constants for the reset and interrupt sequencer
// Assumes: 8-bit core with 13-bit address space
// Notes: Definitions only
`ifndef RIS_DEFINES_VH
`define RIS_DEFINES_VH

`define RIS_RAM_LO 13'h0050
`define RIS_RAM_HI 13'h00ff
`define RIS_NVM_LO 13'h0f00
`define RIS_NVM_HI 13'h1f00
`define RIS_VEC_LO 13'h1ff0
`define RIS_VEC_HI 13'h1fff

`define RIS_VEC_RESET 13'h1ffe
`define RIS_VEC_TRAP 13'h1ffc
`define RIS_VEC_CAN 13'h1ffa
`define RIS_VEC_CTMR 13'h1ff8
`define RIS_VEC_PIN 13'h1ff6
`define RIS_VEC_TMR16 13'h1ff4

`define RIS_PCR_WOI_BIT 5

// Machine cycle = two clocks; 1.5 cycles is exactly 3 clocks
`define RIS_PIN_LOW_CLKS 4'h3
`define RIS_POR_CLKS 4096

`define RIS_SRC_NONE 3'h0
`define RIS_SRC_RESET 3'h1
`define RIS_SRC_TRAP 3'h2
`define RIS_SRC_CAN 3'h3
`define RIS_SRC_CTMR 3'h4
`define RIS_SRC_PIN 3'h5
`define RIS_SRC_TMR16 3'h6

`endif

//--- core/ris_reset_gen.v
// Purpose: Reset source collection and power-up hold
// Assumes: Pin input already synchronised by caller
// Notes: Watchdog reset does not resample mode pins
`timescale 1ns/1ps
`default_nettype none
`include "ris_defines.vh"

module ris_reset_gen #(
    parameter POR_CLKS = `RIS_POR_CLKS,
    parameter WDOG_EN = 1
)
(
    input wire i_clock,
    input wire i_rst_n,
    input wire i_osc_active,
    input wire i_pin_low,
    input wire i_illegal,
    input wire i_watchdog_timeout,
    output wire o_reset,
    output wire o_ext_reset
)
;
    reg [15:0] por_cnt_r;
    reg por_done_r;
    reg [3:0] low_cnt_r;
    reg pin_rst_r;
    reg int_rst_r;

    always @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            por_cnt_r <= 16'h0000;
            por_done_r <= 1'b0;
        end
        else if (i_osc_active && !por_done_r) // RULE_02
        begin
            if (por_cnt_r == POR_CLKS[15:0] - 16'h0001)
                por_done_r <= 1'b1;
            por_cnt_r <= por_cnt_r + 16'h0001;
        end
    end

    always @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            low_cnt_r <= 4'h0;
            pin_rst_r <= 1'b0;
        end
        else if (!i_pin_low)
        begin
            low_cnt_r <= 4'h0;
            pin_rst_r <= 1'b0;
        end
        else
        begin
            if (low_cnt_r != `RIS_PIN_LOW_CLKS)
                low_cnt_r <= low_cnt_r + 4'h1;
            // Hold reset while pin stays low, also past power-up
            if (low_cnt_r == `RIS_PIN_LOW_CLKS - 4'h1 || !por_done_r) // RULE_04 RULE_03
                pin_rst_r <= 1'b1;
        end
    end

    always @(posedge i_clock)
    begin
        if (!i_rst_n)
            int_rst_r <= 1'b0;
        else
            int_rst_r <= i_illegal || (WDOG_EN != 0 && i_watchdog_timeout); // RULE_05 RULE_07 RULE_09
    end

    assign o_reset = !por_done_r || pin_rst_r || int_rst_r; // RULE_01
    assign o_ext_reset = !por_done_r || pin_rst_r; // RULE_08

endmodule // ris_reset_gen
`default_nettype wire

//--- core/ris_sequencer.v
// Purpose: Reset and interrupt sequencing for an 8-bit core
// Assumes: Core drives fetch, completion and vector handshakes
// Notes: Stacking and unstacking are done by the core on request
`timescale 1ns/1ps
`default_nettype none
`include "ris_defines.vh"

// Operation
// RULE_01: Four reset sources: power, pin, fetch, watchdog
// RULE_02: Hold reset for power-up delay after oscillator
// RULE_03: Pin still low after delay keeps reset
// RULE_04: Pin low 1.5 machine cycles resets
// RULE_05: Opcode fetch outside mapped ranges resets
// RULE_06: Only opcode fetches checked for mapping
// RULE_07: Watchdog timeout resets whole device
// RULE_08: Watchdog reset keeps current operating mode
// RULE_09: Watchdog enable fixed by build parameter
// RULE_10: Reset vectors through 1FFE and sets mask
// RULE_11: Four maskable sources plus software trap
// RULE_12: Accepting interrupt stacks registers, sets mask
// RULE_13: Return restores registers and resumes
// RULE_14: Requests wait until current instruction completes
// RULE_15: Take interrupt only if unmasked and enabled
// RULE_16: External interrupt beats timer when both pending
// RULE_17: Priority CAN, core timer, pins, 16-bit timer
// RULE_18: Software trap taken regardless of mask
// RULE_19: Trap after earlier pending, before later requests
// RULE_20: Software trap vectors through 1FFC
// RULE_21: Mask set blocks all maskable interrupts
// RULE_22: Pin latch clears early, relatches new pulse
// RULE_23: Pin latch is port config bit five
// RULE_24: CAN wake-up source always enabled
// RULE_25: Vector high byte first, then low byte
// RULE_26: Flags and enables merge to one request
module ris_sequencer #(
    parameter POR_CLKS = `RIS_POR_CLKS,
    parameter WDOG_EN = 1
)
(
    input wire i_clock,
    input wire i_rst_n,
    input wire i_osc_active,
    input wire i_reset_pin_n,
    input wire i_watchdog_timeout,
    input wire i_opcode_fetch,
    input wire [12:0] i_fetch_addr,
    input wire i_insn_done,
    input wire i_trap_insn,
    input wire i_return_insn,
    input wire i_mask_clear,
    input wire i_mask_set,
    input wire [4:0] i_can_flags,
    input wire [3:0] i_can_enables,
    input wire [1:0] i_core_flags,
    input wire [1:0] i_core_enables,
    input wire [7:0] i_pins,
    input wire [7:0] i_pin_enables,
    input wire i_pcr_write,
    input wire [7:0] i_pcr_wdata,
    input wire [2:0] i_tmr_flags,
    input wire [2:0] i_tmr_enables,
    input wire i_stack_done,
    input wire i_vec_ack,
    input wire [7:0] i_vec_data,
    output wire o_core_reset,
    output wire o_mode_resample,
    output reg o_mask_bit,
    output wire [7:0] o_port_config_reg,
    output wire o_stack_req,
    output wire o_unstack_req,
    output wire o_vec_req,
    output reg [12:0] o_vec_addr,
    output reg o_pc_load,
    output reg [15:0] o_pc_value,
    output reg [2:0] o_source
)
;
    localparam ST_RUN = 3'h0;
    localparam ST_STACK = 3'h1;
    localparam ST_VEC_HI = 3'h2;
    localparam ST_VEC_LO = 3'h3;
    localparam ST_UNSTACK = 3'h4;
    localparam ST_RESET = 3'h5;

    reg [1:0] pin_sync_r;
    reg [7:0] pins_s1_r;
    reg [7:0] pins_s2_r;
    reg [7:0] pins_prev_r;
    reg pin_latch_r;
    reg [3:0] pend_r;
    reg trap_r;
    reg [2:0] state_r;
    reg [7:0] vec_hi_r;
    reg [4:0] pcr_other_r;
    reg [1:0] pcr_top_r;
    wire reset_w;
    wire illegal_w;
    wire [3:0] req_w;
    wire [3:0] eligible_w;
    wire [3:0] live_w;
    wire [7:0] rise_w;

    function mapped;
        input [12:0] a;
        begin
            mapped = (a >= `RIS_RAM_LO && a <= `RIS_RAM_HI) ||
                     (a >= `RIS_NVM_LO && a <= `RIS_NVM_HI) ||
                     (a >= `RIS_VEC_LO && a <= `RIS_VEC_HI);
        end
    endfunction

    // Data fetches never reset; a stray pointer only corrupts data
    assign illegal_w = i_opcode_fetch && !mapped(i_fetch_addr); // RULE_06 RULE_05

    always @(posedge i_clock)
    begin
        if (!i_rst_n)
        begin
            pin_sync_r <= 2'h3;
            pins_s1_r <= 8'h00;
            pins_s2_r <= 8'h00;
            pins_prev_r <= 8'h00;
        end
        else
        begin
            pin_sync_r <= {pin_sync_r[0], i_reset_pin_n};
            pins_s1_r <= i_pins;
            pins_s2_r <= pins_s1_r;
            pins_prev_r <= pins_s2_r;
        end
    end

    ris_reset_gen #(
        .POR_CLKS(POR_CLKS),
        .WDOG_EN(WDOG_EN)
    ) u_reset_gen (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_osc_active(i_osc_active),
        .i_pin_low(!pin_sync_r[1]),
        .i_illegal(illegal_w),
        .i_watchdog_timeout(i_watchdog_timeout),
        .o_reset(reset_w),
        .o_ext_reset(o_mode_resample)
    );

    assign o_core_reset = reset_w;

    assign rise_w = pins_s2_r & ~pins_prev_r & i_pin_enables;

    // Port config register; latch bit set by hardware wins over clear
    always @(posedge i_clock)
    begin
        if (!i_rst_n || reset_w)
        begin
            pin_latch_r <= 1'b0;
            pcr_other_r <= 5'h00;
            pcr_top_r <= 2'h0;
        end
        else
        begin
            if (i_pcr_write)
            begin
                pcr_other_r <= i_pcr_wdata[4:0];
                pcr_top_r <= i_pcr_wdata[7:6];
            end
            if (|rise_w) // RULE_23
                pin_latch_r <= 1'b1;
            else if (state_r == ST_STACK && o_source == `RIS_SRC_PIN) // RULE_22
                pin_latch_r <= 1'b0;
            else if (i_pcr_write && !i_pcr_wdata[`RIS_PCR_WOI_BIT]) // RULE_23
                pin_latch_r <= 1'b0;
        end
    end

    assign o_port_config_reg = {pcr_top_r, pin_latch_r, pcr_other_r};

    // Index 0 highest: CAN, core timer, pins, 16-bit timer
    assign req_w[0] = i_can_flags[4] || |(i_can_flags[3:0] & i_can_enables); // RULE_24 RULE_26
    assign req_w[1] = |(i_core_flags & i_core_enables); // RULE_26
    assign req_w[2] = pin_latch_r; // RULE_26
    assign req_w[3] = |(i_tmr_flags & i_tmr_enables); // RULE_26 RULE_11

    assign live_w = o_mask_bit ? 4'h0 : req_w; // RULE_21 RULE_15
    // A trap only yields to requests already pending at its fetch
    assign eligible_w = i_trap_insn ? (live_w & pend_r) : live_w; // RULE_19

    assign o_stack_req = (state_r == ST_STACK); // RULE_12
    assign o_unstack_req = (state_r == ST_UNSTACK); // RULE_13
    assign o_vec_req = (state_r == ST_VEC_HI) || (state_r == ST_VEC_LO);

    always @(posedge i_clock)
    begin
        if (!i_rst_n || reset_w)
        begin
            state_r <= ST_RESET;
            o_mask_bit <= 1'b1; // RULE_10
            pend_r <= 4'h0;
            trap_r <= 1'b0;
            vec_hi_r <= 8'h00;
            o_vec_addr <= `RIS_VEC_RESET; // RULE_10
            o_pc_load <= 1'b0;
            o_pc_value <= 16'h0000;
            o_source <= `RIS_SRC_RESET;
        end
        else
        begin
            o_pc_load <= 1'b0;
            case (state_r)
                ST_RESET:
                begin
                    state_r <= ST_VEC_HI;
                end
                ST_RUN:
                begin
                    if (i_mask_set)
                        o_mask_bit <= 1'b1;
                    else if (i_mask_clear)
                        o_mask_bit <= 1'b0;
                    if (trap_r) // RULE_19 RULE_18
                    begin
                        // Trap deferred behind an earlier pending request
                        trap_r <= 1'b0;
                        o_source <= `RIS_SRC_TRAP;
                        o_vec_addr <= `RIS_VEC_TRAP;
                        state_r <= ST_STACK;
                    end
                    else if (i_insn_done) // RULE_14
                    begin
                        // Snapshot at boundary orders trap against later requests
                        pend_r <= req_w; // RULE_19
                        if (i_return_insn)
                            state_r <= ST_UNSTACK;
                        else if (|eligible_w) // RULE_15
                        begin
                            state_r <= ST_STACK;
                            trap_r <= i_trap_insn;
                            if (eligible_w[0]) // RULE_17 RULE_16
                            begin
                                o_source <= `RIS_SRC_CAN;
                                o_vec_addr <= `RIS_VEC_CAN;
                            end
                            else if (eligible_w[1]) // RULE_17
                            begin
                                o_source <= `RIS_SRC_CTMR;
                                o_vec_addr <= `RIS_VEC_CTMR;
                            end
                            else if (eligible_w[2]) // RULE_16
                            begin
                                o_source <= `RIS_SRC_PIN;
                                o_vec_addr <= `RIS_VEC_PIN;
                            end
                            else
                            begin
                                o_source <= `RIS_SRC_TMR16;
                                o_vec_addr <= `RIS_VEC_TMR16;
                            end
                        end
                        else if (i_trap_insn) // RULE_18
                        begin
                            state_r <= ST_STACK;
                            trap_r <= 1'b0;
                            o_source <= `RIS_SRC_TRAP;
                            o_vec_addr <= `RIS_VEC_TRAP; // RULE_20
                        end
                    end
                end
                ST_STACK:
                begin
                    o_mask_bit <= 1'b1; // RULE_12
                    if (i_stack_done)
                        state_r <= ST_VEC_HI;
                end
                ST_VEC_HI:
                begin
                    if (i_vec_ack) // RULE_25
                    begin
                        vec_hi_r <= i_vec_data;
                        o_vec_addr <= o_vec_addr + 13'h0001;
                        state_r <= ST_VEC_LO;
                    end
                end
                ST_VEC_LO:
                begin
                    if (i_vec_ack) // RULE_25
                    begin
                        o_pc_value <= {vec_hi_r, i_vec_data};
                        o_pc_load <= 1'b1;
                        state_r <= ST_RUN;
                    end
                end
                ST_UNSTACK:
                begin
                    // Core restores condition flags; mask bit is cleared here on completion
                    if (i_stack_done) // RULE_13
                    begin
                        o_mask_bit <= 1'b0;
                        state_r <= ST_RUN;
                    end
                end
                default:
                begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

endmodule // ris_sequencer
`default_nettype wire

//--- sim/ris_seq_chk.sv
// Purpose: Port checks for the reset and interrupt sequencer
// Assumes: One clock, synchronous active-low reset
// Notes: Bound into every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module ris_seq_chk (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_reset_pin_n,
    input wire logic i_watchdog_timeout,
    input wire logic i_opcode_fetch,
    input wire logic [12:0] i_fetch_addr,
    input wire logic i_insn_done,
    input wire logic i_trap_insn,
    input wire logic i_stack_done,
    input wire logic i_vec_ack,
    input wire logic o_core_reset,
    input wire logic o_mode_resample,
    input wire logic o_mask_bit,
    input wire logic o_stack_req,
    input wire logic o_unstack_req,
    input wire logic o_vec_req,
    input wire logic [12:0] o_vec_addr,
    input wire logic o_pc_load
);
    default clocking dc @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // Done pulses only count in the run state
    wire logic busy = o_stack_req || o_unstack_req || o_vec_req || o_core_reset || o_pc_load;
    wire logic unmapped = !((i_fetch_addr >= 13'h0050 && i_fetch_addr <= 13'h00ff)
        || (i_fetch_addr >= 13'h0f00 && i_fetch_addr <= 13'h1f00) || i_fetch_addr >= 13'h1ff0);
    property p_load_mask;
        o_pc_load |-> o_mask_bit;
    endproperty
    a_load_mask: assert property (p_load_mask) else $error("mask clear at load");
    property p_vec_step;
        o_vec_req && i_vec_ack && !o_vec_addr[0] |=> o_vec_addr == $past(o_vec_addr) + 13'h1;
    endproperty
    a_vec_step: assert property (p_vec_step) else $error("bad low byte address");
    property p_vec_load;
        o_vec_req && i_vec_ack && o_vec_addr[0] |=> o_pc_load;
    endproperty
    a_vec_load: assert property (p_vec_load) else $error("no load after low byte");
    property p_stack_vec;
        o_stack_req && i_stack_done |=> o_vec_req && o_mask_bit;
    endproperty
    a_stack_vec: assert property (p_stack_vec) else $error("no vector after stack");
    property p_unmapped;
        i_opcode_fetch && unmapped && !o_core_reset |-> ##[1:2] o_core_reset && !o_mode_resample;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped fetch kept");
    property p_wdog;
        i_watchdog_timeout && !o_core_reset |-> ##[1:2] o_core_reset && !o_mode_resample;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog reset wrong");
    property p_pin;
        !i_reset_pin_n [*6] |-> ##[1:2] o_core_reset && o_mode_resample;
    endproperty
    a_pin: assert property (p_pin) else $error("pin reset missing");
    property p_masked;
        o_mask_bit && i_insn_done && !i_trap_insn && !busy |=> !o_stack_req;
    endproperty
    a_masked: assert property (p_masked) else $error("masked request taken");
    property p_trap;
        i_insn_done && i_trap_insn && !busy |=> o_stack_req;
    endproperty
    a_trap: assert property (p_trap) else $error("trap not taken");
    property p_return;
        o_unstack_req && i_stack_done |-> ##[1:2] !o_mask_bit;
    endproperty
    a_return: assert property (p_return) else $error("mask kept after return");
    c_trap: cover property (i_insn_done && i_trap_insn && o_mask_bit);
    c_return: cover property (o_unstack_req && i_stack_done);
    c_fetch_rst: cover property (o_core_reset && !o_mode_resample);
endmodule // ris_seq_chk
bind ris_sequencer ris_seq_chk u_chk (.*);
`default_nettype wire

//--- sim/ris_core_model.sv
// Purpose: Core side of stacking and vector reads
// Assumes: Requests stand until answered
// Notes: i_slow stretches each answer to four clocks
`timescale 1ns/1ps
`default_nettype none
module ris_core_model (
    input wire logic i_clock,
    input wire logic i_slow,
    input wire logic i_stack_req,
    input wire logic i_unstack_req,
    input wire logic i_vec_req,
    input wire logic [12:0] i_vec_addr,
    output var logic o_stack_done,
    output var logic o_vec_ack,
    output var logic [7:0] o_vec_data
);
    logic [1:0] wait_r = 2'h0;
    initial {o_stack_done, o_vec_ack, o_vec_data} = 10'h0;
    always @(posedge i_clock)
    begin
        o_stack_done <= 1'b0;
        o_vec_ack <= 1'b0;
        // Idle lane toggles so stale data never passes as a vector
        o_vec_data <= ~o_vec_data;
        wait_r <= 2'h0;
        if ((i_stack_req || i_unstack_req || i_vec_req) && !o_stack_done && !o_vec_ack)
        begin
            wait_r <= wait_r + 2'h1;
            if (!i_slow || wait_r == 2'h3)
            begin
                o_stack_done <= !i_vec_req;
                o_vec_ack <= i_vec_req;
                // Each vector byte holds its own low address byte
                if (i_vec_req)
                    o_vec_data <= i_vec_addr[7:0];
            end
        end
    end
endmodule // ris_core_model
`default_nettype wire

//--- sim/ris_sequencer_test.sv
// Purpose: Self-checking bench for the reset and interrupt sequencer
// Assumes: Inputs change on the falling edge
// Notes: Power-up hold cut to 16 clocks
`timescale 1ns/1ps
`default_nettype none
module ris_sequencer_test;
    typedef struct packed {logic [18:0] req; logic [2:0] src; logic [15:0] pc;} ris_row_t;
    ris_row_t rows [6] = '{'{19'h22000, 3'h3, 16'hfafb}, '{19'h40000, 3'h3, 16'hfafb},
        '{19'h00a80, 3'h4, 16'hf8f9}, '{19'h00024, 3'h6, 16'hf4f5},
        '{19'h11280, 3'h3, 16'hfafb}, '{19'h00692, 3'h4, 16'hf8f9}};
    logic [12:0] legal [6] = '{13'h0050, 13'h00ff, 13'h0f00, 13'h1f00, 13'h1ff0, 13'h1fff};
    logic [12:0] bad [3] = '{13'h004f, 13'h1f01, 13'h1fef};
    logic i_clock = 1'b0, i_rst_n = 1'b0, i_osc_active = 1'b0, i_reset_pin_n = 1'b0;
    logic i_watchdog_timeout = 1'b0, i_opcode_fetch = 1'b0, i_insn_done = 1'b0;
    logic i_trap_insn = 1'b0, i_return_insn = 1'b0, i_mask_clear = 1'b0, i_mask_set = 1'b0;
    logic i_pcr_write = 1'b0, slow = 1'b0;
    logic [12:0] i_fetch_addr = 13'h0000;
    logic [4:0] i_can_flags = 5'h00;
    logic [3:0] i_can_enables = 4'h0;
    logic [1:0] i_core_flags = 2'h0, i_core_enables = 2'h0;
    logic [2:0] i_tmr_flags = 3'h0, i_tmr_enables = 3'h0, o_source;
    logic [7:0] i_pins = 8'h00, i_pin_enables = 8'h00, i_pcr_wdata = 8'h00;
    logic [7:0] i_vec_data, o_port_config_reg;
    logic i_stack_done, i_vec_ack, o_core_reset, o_mode_resample, o_mask_bit, o_pc_load;
    logic o_stack_req, o_unstack_req, o_vec_req;
    logic [12:0] o_vec_addr;
    logic [15:0] o_pc_value;
    int err_count = 0, n_tests = 0;
    ris_sequencer #(.POR_CLKS(16), .WDOG_EN(1)) uut (.*);
    ris_core_model u_core (.i_clock(i_clock), .i_slow(slow), .i_stack_req(o_stack_req),
        .i_unstack_req(o_unstack_req), .i_vec_req(o_vec_req), .i_vec_addr(o_vec_addr),
        .o_stack_done(i_stack_done), .o_vec_ack(i_vec_ack), .o_vec_data(i_vec_data));
    always #25 i_clock = ~i_clock;
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        if (err_count == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    task automatic set_req(input logic [18:0] v);
        {i_can_flags, i_can_enables, i_core_flags, i_core_enables, i_tmr_flags, i_tmr_enables} = v;
    endtask
    task automatic done(input logic trap, input logic ret);
        {i_insn_done, i_trap_insn, i_return_insn} = {1'b1, trap, ret};
        tick(1);
        {i_insn_done, i_trap_insn, i_return_insn} = 3'h0;
    endtask
    task automatic mask(input logic clr);
        {i_mask_clear, i_mask_set} = {clr, ~clr};
        tick(1);
        {i_mask_clear, i_mask_set} = 2'h0;
    endtask
    task automatic quiet;
        repeat (6)
        begin
            tick(1);
            chk("stack_req", 16'(o_stack_req), 16'h0);
            chk("core_reset", 16'(o_core_reset), 16'h0);
        end
    endtask
    task automatic wait_pc(input logic [15:0] pc, input logic [2:0] src);
        int k = 0;
        while (o_pc_load !== 1'b1 && k < 200)
        begin
            tick(1);
            k++;
        end
        chk("pc_load", 16'(o_pc_load), 16'h1);
        chk("pc", o_pc_value, pc);
        chk("source", 16'(o_source), 16'(src));
        chk("mask", 16'(o_mask_bit), 16'h1);
        tick(1);
    endtask
    task automatic wait_rst(input logic resample);
        int k = 0;
        while (o_core_reset !== 1'b1 && k < 10)
        begin
            tick(1);
            k++;
        end
        chk("core_reset", 16'(o_core_reset), 16'h1);
        chk("resample", 16'(o_mode_resample), 16'(resample));
    endtask
    task automatic ret_wait;
        int k = 0;
        done(1'b0, 1'b1);
        while (o_unstack_req !== 1'b0 && k < 40)
        begin
            tick(1);
            k++;
        end
        tick(1);
        chk("mask", 16'(o_mask_bit), 16'h0);
    endtask
    task automatic service(input logic [15:0] pc, input logic [2:0] src);
        mask(1'b1);
        done(1'b0, 1'b0);
        wait_pc(pc, src);
        ret_wait();
    endtask
    initial
    begin
        tick(8);
        i_rst_n = 1'b1;
        i_reset_pin_n = 1'b1;
        tick(12);
        chk("core_reset", 16'(o_core_reset), 16'h1);
        {i_osc_active, i_reset_pin_n} = 2'h2;
        tick(30);
        chk("core_reset", 16'(o_core_reset), 16'h1);
        i_reset_pin_n = 1'b1;
        wait_pc(16'hfeff, 3'h1);
        set_req(19'h003c0);
        done(1'b0, 1'b0);
        quiet();
        set_req(19'h0864a);
        mask(1'b1);
        done(1'b0, 1'b0);
        quiet();
        foreach (rows[r])
        begin
            set_req(rows[r].req);
            service(rows[r].pc, rows[r].src);
            set_req(19'h0);
        end
        mask(1'b0);
        done(1'b1, 1'b0);
        wait_pc(16'hfcfd, 3'h2);
        ret_wait();
        slow = 1'b1;
        set_req(19'h003c0);
        mask(1'b0);
        done(1'b0, 1'b0);
        mask(1'b1);
        done(1'b1, 1'b0);
        wait_pc(16'hf8f9, 3'h4);
        wait_pc(16'hfcfd, 3'h2);
        set_req(19'h0);
        ret_wait();
        slow = 1'b0;
        {i_pin_enables, i_pins} = 16'h0101;
        set_req(19'h00024);
        mask(1'b0);
        tick(4);
        chk("latch", 16'(o_port_config_reg[5]), 16'h1);
        i_pcr_wdata = 8'hdf;
        {i_pcr_write, i_pins} = 9'h100;
        tick(1);
        i_pcr_write = 1'b0;
        tick(1);
        chk("pcr", 16'(o_port_config_reg), 16'h00df);
        i_pins = 8'h01;
        tick(4);
        chk("latch", 16'(o_port_config_reg[5]), 16'h1);
        service(16'hf6f7, 3'h5);
        chk("latch", 16'(o_port_config_reg[5]), 16'h0);
        set_req(19'h0);
        foreach (legal[a])
        begin
            {i_opcode_fetch, i_fetch_addr} = {1'b1, legal[a]};
            tick(1);
            {i_opcode_fetch, i_fetch_addr} = {1'b0, bad[a % 3]};
            quiet();
        end
        foreach (bad[a])
        begin
            {i_opcode_fetch, i_fetch_addr} = {1'b1, bad[a]};
            tick(1);
            i_opcode_fetch = 1'b0;
            wait_rst(1'b0);
            wait_pc(16'hfeff, 3'h1);
        end
        i_watchdog_timeout = 1'b1;
        tick(1);
        i_watchdog_timeout = 1'b0;
        wait_rst(1'b0);
        wait_pc(16'hfeff, 3'h1);
        i_reset_pin_n = 1'b0;
        tick(2);
        i_reset_pin_n = 1'b1;
        quiet();
        i_reset_pin_n = 1'b0;
        tick(8);
        wait_rst(1'b1);
        i_reset_pin_n = 1'b1;
        wait_pc(16'hfeff, 3'h1);
        results();
    end
    initial
    begin
        #500_000;
        err_count++;
        results();
    end
endmodule // ris_sequencer_test
`default_nettype wire
